// ===== pkg/aux_defs.svh
// register map, field positions, reset values and code constants
`ifndef AUX_DEFS_SVH
`define AUX_DEFS_SVH

`define AUX_ADR_CTRL    8'h00
`define AUX_ADR_STATUS  8'h04
`define AUX_ADR_M1      8'h08
`define AUX_ADR_M2      8'h0c
`define AUX_ADR_M3      8'h10
`define AUX_ADR_S       8'h14
`define AUX_ADR_T       8'h18
`define AUX_ADR_B       8'h1c
`define AUX_ADR_CMD     8'h20
`define AUX_ADR_ALONE   8'h24

`define AUX_CTRL_FAST   0
`define AUX_CTRL_PLURAL 1
`define AUX_CTRL_DIG_LO 4
`define AUX_CTRL_DIG_HI 7
`define AUX_CTRL_GSH_LO 8
`define AUX_CTRL_GSH_HI 12
`define AUX_CTRL_RESET  32'h0000_0180
`define AUX_ALONE_RESET 32'h4000_0007

`define AUX_ST_BUSY_LO  0
`define AUX_ST_ALONE    8
`define AUX_ST_GROUP    9
`define AUX_ST_RANGE    10
`define AUX_ST_OVERRUN  11
`define AUX_ST_SUBPROG  12
`define AUX_ST_STOP     13

`define AUX_CMD_CNT_LO  0
`define AUX_CMD_CNT_HI  1
`define AUX_CMD_GO_M    4
`define AUX_CMD_GO_S    5
`define AUX_CMD_GO_T    6
`define AUX_CMD_GO_B    7

`define AUX_CODE_STOP   32'h0000_0000
`define AUX_CODE_OPT    32'h0000_0001
`define AUX_CODE_END    32'h0000_0002
`define AUX_CODE_REWIND 32'h0000_001e
`define AUX_CODE_CALL   32'h0000_0062
`define AUX_CODE_RET    32'h0000_0063
`define AUX_MAX_FIRST   32'h05f5_e0ff
`define AUX_MAX_OTHER   32'h0000_ffff

`endif

// ===== pkg/aux_pkg.sv
// types shared by the code handshake design
package aux_pkg;
	typedef enum logic [1:0] {
		hs_idle       = 2'b00,
		hs_wait_rise  = 2'b01,
		hs_wait_fall  = 2'b10,
		hs_wait_match = 2'b11
	} hs_state_t;
endpackage : aux_pkg

// ===== hw/aux_channel.sv
// one function's code holder with conventional or toggle strobe handshake
`timescale 1ns/1ps
`include "aux_defs.svh"
module aux_channel #(
	parameter int WIDTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             issue_i,
	input  wire logic [WIDTH-1:0] code_i,
	input  wire logic             fast_i,
	input  wire logic             shared_fin_i,
	input  wire logic             fast_fin_i,
	output logic                  strobe_o,
	output logic [WIDTH-1:0]      code_o,
	output logic                  busy_o
);
	aux_pkg::hs_state_t state;

	// code stays put until the next issue of this function
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_o <= '0;
		end else if (issue_i && !busy_o) begin
			code_o <= code_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= aux_pkg::hs_idle;
			strobe_o <= 1'b0;
		end else begin
			unique case (state)
				aux_pkg::hs_idle: begin
					if (issue_i) begin
						if (fast_i) begin
							strobe_o <= ~strobe_o;
							state    <= aux_pkg::hs_wait_match;
						end else begin
							strobe_o <= 1'b1;
							state    <= aux_pkg::hs_wait_rise;
						end
					end
				end
				aux_pkg::hs_wait_rise: begin
					if (shared_fin_i) begin
						strobe_o <= 1'b0;
						state    <= aux_pkg::hs_wait_fall;
					end
				end
				aux_pkg::hs_wait_fall: begin
					if (!shared_fin_i) begin
						state <= aux_pkg::hs_idle;
					end
				end
				aux_pkg::hs_wait_match: begin
					if (fast_fin_i == strobe_o) begin
						state <= aux_pkg::hs_idle;
					end
				end
			endcase
		end
	end

	assign busy_o = (state != aux_pkg::hs_idle);
endmodule : aux_channel

// ===== hw/aux_code_if.sv
// auxiliary function code output and strobe handshake toward the machine logic controller
`timescale 1ns/1ps
`include "aux_defs.svh"
module aux_code_if (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        shared_completion_in_i,
	input  wire logic        aux_fast_completion_in_i,
	input  wire logic        spindle_fast_completion_in_i,
	input  wire logic        tool_fast_completion_in_i,
	input  wire logic        second_fast_completion_in_i,
	output logic      [31:0] aux_code_o,
	output logic      [31:0] aux_code_second_o,
	output logic      [31:0] aux_code_third_o,
	output logic             aux_code_strobe_o,
	output logic             aux_code_strobe_second_o,
	output logic             aux_code_strobe_third_o,
	output logic      [31:0] spindle_code_o,
	output logic             spindle_strobe_o,
	output logic      [31:0] tool_code_o,
	output logic             tool_strobe_o,
	output logic      [31:0] second_code_o,
	output logic             second_strobe_o
);
	logic [31:0] ctrl;
	logic [31:0] alone_mask;
	logic [31:0] mcode [3];
	logic [31:0] scode;
	logic [31:0] tcode;
	logic [31:0] bcode;
	logic [5:0]  flags;
	logic        req;
	logic        wr;
	logic [7:0]  adr;
	logic [31:0] next_rd;
	logic        fast;
	logic        plural;
	logic [3:0]  busy;
	logic        any_busy;
	logic [1:0]  cnt;
	logic [2:0]  present;
	logic        go_m;
	logic        go_s;
	logic        go_t;
	logic        go_b;
	logic        err_alone;
	logic        err_group;
	logic        err_range;
	logic        is_sub;
	logic        is_stop;
	logic        m_ok;
	logic        issue_m;
	logic        issue_s;
	logic        issue_t;
	logic        issue_b;
	logic        refused;
	logic [31:0] next_a2;
	logic [31:0] next_a3;

	// largest value with the given number of decimal digits, plus one
	function automatic logic [31:0] digit_limit(input logic [3:0] dig);
		unique case (dig)
			4'h1:    digit_limit = 32'h0000_000a;
			4'h2:    digit_limit = 32'h0000_0064;
			4'h3:    digit_limit = 32'h0000_03e8;
			4'h4:    digit_limit = 32'h0000_2710;
			4'h5:    digit_limit = 32'h0001_86a0;
			4'h6:    digit_limit = 32'h000f_4240;
			4'h7:    digit_limit = 32'h0098_9680;
			default: digit_limit = 32'h05f5_e100;
		endcase
	endfunction : digit_limit

	function automatic logic must_be_alone(input logic [31:0] code, input logic [31:0] mask);
		must_be_alone = (code[31:5] == 27'h0) ? mask[code[4:0]] : 1'b0;
	endfunction : must_be_alone

	function automatic logic [31:0] group_of(input logic [31:0] code, input logic [4:0] sh);
		group_of = code >> sh;
	endfunction : group_of

	function automatic logic is_subprog(input logic [31:0] code);
		is_subprog = (code == `AUX_CODE_CALL) || (code == `AUX_CODE_RET);
	endfunction : is_subprog

	// bus decode: single-cycle ack, one action per request
	assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr     = req && wb_we_i;
	assign adr    = {wb_adr_i[7:2], 2'b00};
	assign fast   = ctrl[`AUX_CTRL_FAST];
	assign plural = ctrl[`AUX_CTRL_PLURAL];
	assign any_busy = |busy;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl       <= `AUX_CTRL_RESET;
			alone_mask <= `AUX_ALONE_RESET;
			scode      <= '0;
			tcode      <= '0;
			bcode      <= '0;
		end else if (wr) begin
			unique case (adr)
				`AUX_ADR_CTRL:  ctrl       <= merge(ctrl, wb_dat_i, wb_sel_i);
				`AUX_ADR_ALONE: alone_mask <= merge(alone_mask, wb_dat_i, wb_sel_i);
				`AUX_ADR_S:     scode      <= merge(scode, wb_dat_i, wb_sel_i);
				`AUX_ADR_T:     tcode      <= merge(tcode, wb_dat_i, wb_sel_i);
				`AUX_ADR_B:     bcode      <= merge(bcode, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_mreg
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					mcode[g] <= '0;
				end else if (wr && adr == `AUX_ADR_M1 + 8'(4 * g)) begin
					mcode[g] <= merge(mcode[g], wb_dat_i, wb_sel_i);
				end
			end
		end
	endgenerate

	// block command decode; count 0 is read as one code
	assign go_m = wr && adr == `AUX_ADR_CMD && wb_sel_i[0] && wb_dat_i[`AUX_CMD_GO_M];
	assign go_s = wr && adr == `AUX_ADR_CMD && wb_sel_i[0] && wb_dat_i[`AUX_CMD_GO_S];
	assign go_t = wr && adr == `AUX_ADR_CMD && wb_sel_i[0] && wb_dat_i[`AUX_CMD_GO_T];
	assign go_b = wr && adr == `AUX_ADR_CMD && wb_sel_i[0] && wb_dat_i[`AUX_CMD_GO_B];
	assign cnt  = (wb_dat_i[`AUX_CMD_CNT_HI:`AUX_CMD_CNT_LO] == 2'd0) ? 2'd1 :
		wb_dat_i[`AUX_CMD_CNT_HI:`AUX_CMD_CNT_LO];
	assign present = {cnt == 2'd3, cnt >= 2'd2, 1'b1};

	always_comb begin
		err_alone = 1'b0;
		err_group = 1'b0;
		err_range = 1'b0;
		is_sub    = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (present[i]) begin
				if (mcode[i] >= digit_limit(ctrl[`AUX_CTRL_DIG_HI:`AUX_CTRL_DIG_LO])) begin
					err_range = 1'b1;
				end
				if (plural && mcode[i] > ((i == 0) ? `AUX_MAX_FIRST : `AUX_MAX_OTHER)) begin
					err_range = 1'b1;
				end
				if (is_subprog(mcode[i])) begin
					is_sub = 1'b1;
				end
				if (cnt != 2'd1 && must_be_alone(mcode[i], alone_mask)) begin
					err_alone = 1'b1;
				end
				for (int j = i + 1; j < 3; j++) begin
					if (present[j] && group_of(mcode[i], ctrl[`AUX_CTRL_GSH_HI:`AUX_CTRL_GSH_LO])
						== group_of(mcode[j], ctrl[`AUX_CTRL_GSH_HI:`AUX_CTRL_GSH_LO])) begin
						err_group = 1'b1;
					end
				end
			end
		end
	end

	assign is_stop = (mcode[0] == `AUX_CODE_STOP) || (mcode[0] == `AUX_CODE_OPT) ||
		(mcode[0] == `AUX_CODE_END) || (mcode[0] == `AUX_CODE_REWIND);
	assign m_ok = !err_alone && !err_group && !err_range && !is_sub;

	// conventional scheme shares one completion line, so no command is taken while any function is open
	assign refused = (go_m && busy[0]) || (go_s && busy[1]) || (go_t && busy[2]) ||
		(go_b && busy[3]) || (!fast && (go_m || go_s || go_t || go_b) && any_busy);
	assign issue_m = go_m && m_ok && !(refused);
	assign issue_s = go_s && !refused;
	assign issue_t = go_t && !refused;
	assign issue_b = go_b && !refused;

	// sticky status: hardware set wins over a software write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~((wr && adr == `AUX_ADR_STATUS && wb_sel_i[1]) ?
				wb_dat_i[`AUX_ST_STOP:`AUX_ST_ALONE] : 6'h00)) |
				{issue_m && is_stop,
				 go_m && is_sub && !refused && !err_alone && !err_group && !err_range,
				 refused,
				 go_m && err_range,
				 go_m && err_group,
				 go_m && err_alone};
		end
	end

	always_comb begin
		unique case (adr)
			`AUX_ADR_CTRL:   next_rd = ctrl;
			`AUX_ADR_STATUS: next_rd = {18'h0, flags, 4'h0, busy};
			`AUX_ADR_M1:     next_rd = mcode[0];
			`AUX_ADR_M2:     next_rd = mcode[1];
			`AUX_ADR_M3:     next_rd = mcode[2];
			`AUX_ADR_S:      next_rd = scode;
			`AUX_ADR_T:      next_rd = tcode;
			`AUX_ADR_B:      next_rd = bcode;
			`AUX_ADR_ALONE:  next_rd = alone_mask;
			default:         next_rd = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= next_rd;
		end
	end

	aux_channel #(.WIDTH(32)) u_m (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.issue_i      (issue_m),
		.code_i       (mcode[0]),
		.fast_i       (fast),
		.shared_fin_i (shared_completion_in_i),
		.fast_fin_i   (aux_fast_completion_in_i),
		.strobe_o     (aux_code_strobe_o),
		.code_o       (aux_code_o),
		.busy_o       (busy[0])
	);

	aux_channel #(.WIDTH(32)) u_s (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.issue_i      (issue_s),
		.code_i       (scode),
		.fast_i       (fast),
		.shared_fin_i (shared_completion_in_i),
		.fast_fin_i   (spindle_fast_completion_in_i),
		.strobe_o     (spindle_strobe_o),
		.code_o       (spindle_code_o),
		.busy_o       (busy[1])
	);

	aux_channel #(.WIDTH(32)) u_t (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.issue_i      (issue_t),
		.code_i       (tcode),
		.fast_i       (fast),
		.shared_fin_i (shared_completion_in_i),
		.fast_fin_i   (tool_fast_completion_in_i),
		.strobe_o     (tool_strobe_o),
		.code_o       (tool_code_o),
		.busy_o       (busy[2])
	);

	aux_channel #(.WIDTH(32)) u_b (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.issue_i      (issue_b),
		.code_i       (bcode),
		.fast_i       (fast),
		.shared_fin_i (shared_completion_in_i),
		.fast_fin_i   (second_fast_completion_in_i),
		.strobe_o     (second_strobe_o),
		.code_o       (second_code_o),
		.busy_o       (busy[3])
	);

	// second and third codes ride on the first code's handshake; single mode zeroes them
	assign next_a2 = (plural && present[1]) ? mcode[1] : 32'h0;
	assign next_a3 = (plural && present[2]) ? mcode[2] : 32'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_code_second_o <= '0;
			aux_code_third_o  <= '0;
		end else if (issue_m) begin
			aux_code_second_o <= next_a2;
			aux_code_third_o  <= next_a3;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_code_strobe_second_o <= 1'b0;
			aux_code_strobe_third_o  <= 1'b0;
		end else if (issue_m && fast) begin
			aux_code_strobe_second_o <= aux_code_strobe_second_o ^ (plural && present[1]);
			aux_code_strobe_third_o  <= aux_code_strobe_third_o ^ (plural && present[2]);
		end else if (issue_m) begin
			aux_code_strobe_second_o <= plural && present[1];
			aux_code_strobe_third_o  <= plural && present[2];
		end else if (!fast && shared_completion_in_i && busy[0]) begin
			aux_code_strobe_second_o <= 1'b0;
			aux_code_strobe_third_o  <= 1'b0;
		end
	end
endmodule : aux_code_if

// ===== dv/aux_code_if_sva.sv
// port-level checks for the auxiliary code handshake block
`timescale 1ns/1ps
module aux_code_if_sva (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        shared_completion_in_i,
	input wire logic        aux_fast_completion_in_i,
	input wire logic        second_fast_completion_in_i,
	input wire logic [31:0] aux_code_o,
	input wire logic        aux_code_strobe_o,
	input wire logic        aux_code_strobe_second_o,
	input wire logic [31:0] second_code_o,
	input wire logic        second_strobe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take;
	logic fast;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// mode is not on a port, so it is mirrored from control writes
	always_ff @(posedge clk_i) begin
		if (rst_i)
			fast <= 1'b0;
		else if (take && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0])
			fast <= wb_dat_i[0];
	end
	sequence conv_wait_s;
		!fast && aux_code_strobe_o && !shared_completion_in_i;
	endsequence
	sequence conv_seen_s;
		!fast && aux_code_strobe_o && shared_completion_in_i;
	endsequence
	bus_ack_a: assert property (take |=> wb_ack_o)
		else $error("bus request not acknowledged next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	reset_low_a: assert property ($fell(rst_i) |-> !aux_code_strobe_o && !second_strobe_o)
		else $error("strobe high after reset");
	conv_hold_a: assert property (conv_wait_s |=> aux_code_strobe_o)
		else $error("strobe dropped before completion rose");
	conv_drop_a: assert property (conv_seen_s |=> !aux_code_strobe_o)
		else $error("strobe kept after completion rose");
	fast_wait_a: assert property (fast && aux_code_strobe_o != aux_fast_completion_in_i
		|=> $stable(aux_code_strobe_o))
		else $error("strobe toggled before completion matched");
	b_wait_a: assert property (fast && second_strobe_o != second_fast_completion_in_i
		|=> $stable(second_strobe_o))
		else $error("second strobe toggled before completion matched");
	plural_pair_a: assert property ($changed(aux_code_strobe_second_o)
		|-> $changed(aux_code_strobe_o))
		else $error("second strobe moved alone");
	m_code_a: assert property ($changed(aux_code_o) |-> $changed(aux_code_strobe_o))
		else $error("code changed without strobe");
	b_hold_a: assert property ($changed(second_code_o) |-> $changed(second_strobe_o))
		else $error("second code changed without strobe");
endmodule : aux_code_if_sva

// ===== dv/plc_model.sv
// behavioural machine logic controller answering the strobe handshakes
`timescale 1ns/1ps
module plc_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       fast_i,
	input  wire logic [3:0] dly_i,
	input  wire logic [3:0] strobe_i,
	output logic            fin_o,
	output logic [3:0]      fast_fin_o
);
	logic [3:0] cnt;
	logic       pend;
	assign pend = fast_i ? (strobe_i != fast_fin_o) : (|strobe_i && !fin_o);
	// one delay counter: a slow answer stalls every function alike
	always_ff @(posedge clk_i) begin
		if (rst_i || !pend)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			fin_o <= 1'b0;
		else if (!fast_i && pend && cnt >= dly_i)
			fin_o <= 1'b1;
		else if (strobe_i == 4'h0)
			fin_o <= 1'b0;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			fast_fin_o <= 4'h0;
		else if (fast_i && pend && cnt >= dly_i)
			fast_fin_o <= strobe_i;
	end
endmodule : plc_model

// ===== dv/aux_code_if_tb.sv
// self-checking bench for the auxiliary code handshake block
`timescale 1ns/1ps
module aux_code_if_tb;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         cyc = 1'b0;
	logic         we = 1'b0;
	logic         fast = 1'b0;
	logic [7:0]   adr = 8'h00;
	logic [31:0]  wdat = 32'h0, vb = 32'h0, rdat, dat_o, cm, cm2, cm3, cs, ct, cb, v;
	logic [3:0]   dly = 4'h8, ffin, stv;
	logic         ack, shared_completion_in, sm, sm2, sm3, ss, st, sb, p;
	logic [15:0]  lfsr = 16'h269a;
	logic [127:0] cv;
	logic [7:0]   fadr [4] = '{8'h08, 8'h14, 8'h18, 8'h1c};
	logic [31:0]  stops [4] = '{32'h0, 32'h1, 32'h2, 32'h1e};
	int           fails = 0, checks = 0;
	assign stv = {sb, st, ss, sm};
	assign cv = {cb, ct, cs, cm};
	always #10 clk_i = ~clk_i;
	aux_code_if aux_code_if_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .shared_completion_in_i(shared_completion_in), .aux_fast_completion_in_i(ffin[0]),
		.spindle_fast_completion_in_i(ffin[1]), .tool_fast_completion_in_i(ffin[2]),
		.second_fast_completion_in_i(ffin[3]), .aux_code_o(cm), .aux_code_second_o(cm2),
		.aux_code_third_o(cm3), .aux_code_strobe_o(sm), .aux_code_strobe_second_o(sm2),
		.aux_code_strobe_third_o(sm3), .spindle_code_o(cs), .spindle_strobe_o(ss),
		.tool_code_o(ct), .tool_strobe_o(st), .second_code_o(cb), .second_strobe_o(sb));
	plc_model plc_model_inst (.clk_i, .rst_i, .fast_i(fast), .dly_i(dly), .strobe_i(stv),
		.fin_o(shared_completion_in), .fast_fin_o(ffin));
	function automatic logic [15:0] next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : next
	// conventional strobe rises on issue; fast strobe is the inverse of its old level
	function automatic logic exp_strobe(input logic f, input logic prev);
		return f ? !prev : 1'b1;
	endfunction : exp_strobe
	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic guard(input bit hit);
		if (hit) begin
			fails++;
			test_done;
		end
	endtask : guard
	task automatic check(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		cyc <= 1'b0;
		@(posedge clk_i);
		guard(n >= 50);
	endtask : bus
	task automatic idle;
		int n;
		n = 0;
		do begin
			bus(1'b0, 8'h04, 32'h0);
			n++;
		end while (rdat[3:0] !== 4'h0 && n < 100);
		guard(n >= 100);
	endtask : idle
	task automatic mcase(input logic [31:0] ctl, m1, m2, m3, input logic [7:0] cmd,
		input logic [2:0] es, input logic [5:0] ef);
		logic [31:0] old;
		bus(1'b1, 8'h00, ctl);
		bus(1'b1, 8'h08, m1);
		bus(1'b1, 8'h0c, m2);
		bus(1'b1, 8'h10, m3);
		old = cm;
		bus(1'b1, 8'h20, {24'h0, cmd});
		check("strobes", 32'({sm, sm2, sm3}), 32'(es));
		if (es[2]) check("m1", cm, m1);
		else check("m1 kept", cm, old);
		if (es[2] && !es[1]) check("m2 zero", cm2, 32'h0);
		if (es[1]) check("m2", cm2, m2);
		if (es[0]) check("m3", cm3, m3);
		bus(1'b0, 8'h04, 32'h0);
		check("flags", 32'(rdat[13:8]), 32'(ef));
		idle;
		bus(1'b1, 8'h04, 32'h0000_3f00);
	endtask : mcase
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		check("reset", 32'({sm, sm2, sm3, ss, st, sb}), 32'h0);
		bus(1'b0, 8'h00, 32'h0);
		check("ctrl", rdat, 32'h0000_0180);
		bus(1'b0, 8'h24, 32'h0);
		check("alone", rdat, 32'h4000_0007);
		bus(1'b0, 8'h28, 32'h0);
		check("unmapped", rdat, 32'h0);
		for (int k = 0; k < 4; k++)
			mcase(32'h180, stops[k], 32'h0, 32'h0, 8'h10, 3'b100, 6'h20);
		mcase(32'h180, 32'h62, 32'h0, 32'h0, 8'h10, 3'b000, 6'h10);
		mcase(32'h180, 32'h63, 32'h0, 32'h0, 8'h10, 3'b000, 6'h10);
		mcase(32'h130, 32'h3e7, 32'h0, 32'h0, 8'h10, 3'b100, 6'h00);
		mcase(32'h130, 32'h3e8, 32'h0, 32'h0, 8'h10, 3'b000, 6'h04);
		mcase(32'h182, 32'h5f5_e0ff, 32'hffff, 32'hfffd, 8'h13, 3'b111, 6'h00);
		mcase(32'h182, 32'h100, 32'h1_0000, 32'h200, 8'h13, 3'b000, 6'h04);
		mcase(32'h180, 32'h123, 32'h456, 32'h789, 8'h13, 3'b100, 6'h00);
		mcase(32'h582, 32'h40, 32'h41, 32'h0, 8'h12, 3'b000, 6'h02);
		bus(1'b1, 8'h24, 32'h0000_0100);
		mcase(32'h182, 32'h40, 32'h08, 32'h0, 8'h12, 3'b000, 6'h01);
		for (int r = 0; r < 8; r++) begin
			fast <= r[2];
			bus(1'b1, 8'h00, {31'h0000_00c0, r[2]});
			for (int f = 0; f < 4; f++) begin
				lfsr = next(lfsr);
				v = {16'h0000, lfsr} | 32'h0000_0100;
				dly <= lfsr[3:0] | 4'h2;
				p = stv[f];
				bus(1'b1, fadr[f], v);
				bus(1'b1, 8'h20, 32'h0000_0010 << f);
				check("code", cv[32*f +: 32], v);
				check("strobe", 32'(stv[f]), 32'(exp_strobe(fast, p)));
				if (f == 0) check("b hold", cb, vb);
				if (f == 3) vb = v;
				idle;
			end
		end
		dly <= 4'hf;
		bus(1'b1, 8'h08, 32'h0000_0300);
		bus(1'b1, 8'h20, 32'h0000_0010);
		p = sm;
		bus(1'b1, 8'h20, 32'h0000_0010);
		check("held", 32'(sm), 32'(p));
		bus(1'b0, 8'h04, 32'h0);
		check("overrun", 32'(rdat[11]), 32'h1);
		idle;
		test_done;
	end
endmodule : aux_code_if_tb
bind aux_code_if aux_code_if_sva aux_code_if_sva_inst (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
	.shared_completion_in_i, .aux_fast_completion_in_i, .second_fast_completion_in_i,
	.aux_code_o, .aux_code_strobe_o, .aux_code_strobe_second_o, .second_code_o,
	.second_strobe_o);
